// file: core/fhs_pkg.sv
// constants and types of the link event flag and enable block
package fhs_pkg;
    // register indices; byte address is four times the index
    localparam logic [29:0] FLAGS_IDX = 30'h00000001;
    localparam logic [29:0] ENABLES_IDX = 30'h00000002;
    // reset values
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] ENABLES_RST = 8'h00;
    // field positions
    localparam int CODE_CHANGE_BIT = 7;
    localparam int PKT_END_BIT = 6;
    localparam int PKT_START_BIT = 5;
    localparam int RX_HALF_BIT = 4;
    localparam int RX_DATA_BIT = 3;
    localparam int TX_HALF_BIT = 2;
    localparam int TX_ROOM_BIT = 1;
    localparam int TX_DONE_BIT = 0;
    // bits that latch and clear on read; the rest follow fifo levels
    localparam logic [7:0] LATCHED_MASK = 8'he1;
    // fifo geometry
    localparam int FIFO_CNT_W = 5;
    localparam logic [4:0] FIFO_DEPTH = 5'h10;
    localparam logic [4:0] FIFO_HALF = 5'h08;
    // ahb-lite codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_FLAGS,
        SEL_ENABLES
    } fhs_sel_t;

    typedef enum logic {
        PH_IDLE,
        PH_DATA
    } fhs_phase_t;
endpackage : fhs_pkg

// file: core/fhs_sticky_bit.sv
// one sticky event bit, set wins over clear
module fhs_sticky_bit (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic set,
    input wire logic clr,
    output logic q
);
    logic q_q;
    logic q_d;

    always_comb begin
        q_d = set | (q_q & ~clr);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_q <= 1'b0;
        end else begin
            q_q <= q_d;
        end
    end

    assign q = q_q;
endmodule : fhs_sticky_bit

// file: core/fhs_link_event_irq.sv
// event flags, enables and interrupt of the data link unit
module fhs_link_event_irq (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    input wire logic code_valid,
    input wire logic rx_msg_good,
    input wire logic rx_crc_error,
    input wire logic rx_overrun,
    input wire logic rx_abort,
    input wire logic rx_open_byte,
    input wire logic [4:0] rx_fifo_count,
    input wire logic [4:0] tx_fifo_count,
    input wire logic tx_msg_sent
);
    // word index decode of a byte address
    function automatic fhs_pkg::fhs_sel_t reg_sel(input logic [31:0] addr);
        if (addr[31:2] == fhs_pkg::FLAGS_IDX) begin
            reg_sel = fhs_pkg::SEL_FLAGS;
        end else if (addr[31:2] == fhs_pkg::ENABLES_IDX) begin
            reg_sel = fhs_pkg::SEL_ENABLES;
        end else begin
            reg_sel = fhs_pkg::SEL_NONE;
        end
    endfunction : reg_sel

    // ------------------------------------------------------------
    // bus phase tracking
    fhs_pkg::fhs_phase_t phase_q;
    fhs_pkg::fhs_phase_t phase_d;
    logic wr_pend_q;
    logic wr_pend_d;
    fhs_pkg::fhs_sel_t wsel_q;
    fhs_pkg::fhs_sel_t wsel_d;
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;
    logic hreadyout_q;
    logic accept;
    logic rd_accept;
    fhs_pkg::fhs_sel_t asel;

    // ------------------------------------------------------------
    // flag and enable state
    logic [7:0] enables_q;
    logic [7:0] enables_d;
    logic [7:0] lvl_q;
    logic [7:0] lvl_d;
    logic code_prev_q;
    logic code_prev_d;
    logic irq_q;
    logic irq_d;
    logic [7:0] set_vec;
    logic [7:0] sticky;
    logic [7:0] flags;
    logic [7:0] flags_next;
    logic [7:0] enables_rd;
    logic flags_clr;

    // transfer accepted in its address phase
    always_comb begin
        asel = reg_sel(haddr);
        accept = hsel & hready & (htrans == fhs_pkg::HTRANS_NONSEQ);
        rd_accept = accept & ~hwrite;
    end

    always_comb begin
        phase_d = accept ? fhs_pkg::PH_DATA : fhs_pkg::PH_IDLE;
        wr_pend_d = accept & hwrite;
        wsel_d = accept ? asel : fhs_pkg::SEL_NONE;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_q <= fhs_pkg::PH_IDLE;
            wr_pend_q <= 1'b0;
            wsel_q <= fhs_pkg::SEL_NONE;
            hreadyout_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            wr_pend_q <= wr_pend_d;
            wsel_q <= wsel_d;
            hreadyout_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // event sources
    always_comb begin
        code_prev_d = code_valid;
        set_vec = 8'h00;
        set_vec[fhs_pkg::CODE_CHANGE_BIT] = code_valid ^ code_prev_q;
        set_vec[fhs_pkg::PKT_END_BIT] = rx_msg_good | rx_crc_error
            | rx_overrun | rx_abort;
        set_vec[fhs_pkg::PKT_START_BIT] = rx_open_byte;
        set_vec[fhs_pkg::TX_DONE_BIT] = tx_msg_sent;
    end

    // fifo level flags
    always_comb begin
        lvl_d = 8'h00;
        lvl_d[fhs_pkg::RX_HALF_BIT] = rx_fifo_count > fhs_pkg::FIFO_HALF;
        lvl_d[fhs_pkg::RX_DATA_BIT] = rx_fifo_count != 5'h00;
        lvl_d[fhs_pkg::TX_HALF_BIT] = tx_fifo_count < fhs_pkg::FIFO_HALF;
        lvl_d[fhs_pkg::TX_ROOM_BIT] = tx_fifo_count < fhs_pkg::FIFO_DEPTH;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            code_prev_q <= 1'b0;
            lvl_q <= fhs_pkg::FLAGS_RST;
        end else begin
            code_prev_q <= code_prev_d;
            lvl_q <= lvl_d;
        end
    end

    assign flags_clr = rd_accept & (asel == fhs_pkg::SEL_FLAGS);

    // latched bits as sticky cells, level bits from the registered levels
    // latch or follow per bit
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_flag
            if (fhs_pkg::LATCHED_MASK[gi]) begin : g_sticky
                fhs_sticky_bit u_bit (
                    .hclk(hclk),
                    .hresetn(hresetn),
                    .set(set_vec[gi]),
                    .clr(flags_clr),
                    .q(sticky[gi])
                );
                assign flags[gi] = sticky[gi];
                assign flags_next[gi] = set_vec[gi]
                    | (sticky[gi] & ~flags_clr);
            end else begin : g_level
                assign sticky[gi] = 1'b0;
                assign flags[gi] = lvl_q[gi];
                assign flags_next[gi] = lvl_d[gi];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // enable register, written in the data phase
    always_comb begin
        enables_d = enables_q;
        if (wr_pend_q && wsel_q == fhs_pkg::SEL_ENABLES) begin
            enables_d = hwdata[7:0];
        end
    end

    // read data taken in the address phase; a write still in its
    // data phase is forwarded so a back to back read sees it
    always_comb begin
        enables_rd = enables_d;
        hrdata_d = 32'h00000000;
        if (rd_accept) begin
            case (asel)
                fhs_pkg::SEL_FLAGS: begin
                    hrdata_d = {24'h000000, flags};
                end
                fhs_pkg::SEL_ENABLES: begin
                    hrdata_d = {24'h000000, enables_rd};
                end
                default: begin
                    hrdata_d = 32'h00000000;
                end
            endcase
        end
    end

    always_comb begin
        irq_d = |(flags_next & enables_d);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enables_q <= fhs_pkg::ENABLES_RST;
            hrdata_q <= 32'h00000000;
            irq_q <= 1'b0;
        end else begin
            enables_q <= enables_d;
            hrdata_q <= hrdata_d;
            irq_q <= irq_d;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = fhs_pkg::HRESP_OKAY;
    assign irq = irq_q;
endmodule : fhs_link_event_irq

// file: sim/fhs_chk_sva.sv
// checker of the link event flag and enable block
module fhs_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hrdata,
    input wire logic code_valid,
    input wire logic rx_msg_good,
    input wire logic rx_crc_error,
    input wire logic rx_overrun,
    input wire logic rx_abort,
    input wire logic rx_open_byte,
    input wire logic [4:0] rx_fifo_count,
    input wire logic [4:0] tx_fifo_count,
    input wire logic tx_msg_sent
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // data phase of a flags read, event one edge before its address
    sequence s_rd(ev);
        $past(htrans == fhs_pkg::HTRANS_NONSEQ && !hwrite
            && haddr[31:2] == fhs_pkg::FLAGS_IDX) && $past(ev, 2);
    endsequence
    property p_code;
        ($past(htrans == fhs_pkg::HTRANS_NONSEQ && !hwrite
            && haddr[31:2] == fhs_pkg::FLAGS_IDX)
            && $past(code_valid, 2) != $past(code_valid, 3))
            |-> hrdata[7];
    endproperty
    a_code: assert property (p_code) else $error("code flag");
    property p_pkt_end;
        s_rd(rx_msg_good | rx_crc_error | rx_overrun | rx_abort) |-> hrdata[6];
    endproperty
    a_pkt_end: assert property (p_pkt_end) else $error("end flag");
    property p_start; s_rd(rx_open_byte) |-> hrdata[5]; endproperty
    a_start: assert property (p_start) else $error("start flag");
    property p_done; s_rd(tx_msg_sent) |-> hrdata[0]; endproperty
    a_done: assert property (p_done) else $error("done flag");
    property p_rx_half;
        s_rd(1'b1) |-> hrdata[4] == ($past(rx_fifo_count, 2) > 5'h08);
    endproperty
    a_rx_half: assert property (p_rx_half) else $error("rx half");
    property p_rx_data;
        s_rd(1'b1) |-> hrdata[3] == ($past(rx_fifo_count, 2) != 5'h00);
    endproperty
    a_rx_data: assert property (p_rx_data) else $error("rx data");
    property p_tx_half;
        s_rd(1'b1) |-> hrdata[2] == ($past(tx_fifo_count, 2) < 5'h08);
    endproperty
    a_tx_half: assert property (p_tx_half) else $error("tx half");
    property p_tx_room;
        s_rd(1'b1) |-> hrdata[1] == ($past(tx_fifo_count, 2) < 5'h10);
    endproperty
    a_tx_room: assert property (p_tx_room) else $error("tx room");
endmodule : fhs_chk
bind fhs_link_event_irq fhs_chk u_chk (.hclk, .hresetn, .haddr, .htrans,
    .hwrite, .hrdata, .code_valid, .rx_msg_good, .rx_crc_error, .rx_overrun,
    .rx_abort, .rx_open_byte, .rx_fifo_count, .tx_fifo_count, .tx_msg_sent);

// file: sim/tb_top.sv
// self-checking bench of the link event flag and enable block
module tb_top;
    timeunit 1ns / 1ns;
    logic hclk = 1'b0, hresetn, hsel, hwrite, code_valid, hreadyout;
    logic hresp, irq;
    logic [1:0] htrans;
    logic [4:0] rx_fifo_count, tx_fifo_count;
    logic [5:0] p;
    logic [31:0] haddr, hwdata, hrdata;
    int bad_count, comparisons, cyc;
    fhs_link_event_irq dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
        .hreadyout, .hresp, .irq, .code_valid, .rx_msg_good(p[1]),
        .rx_crc_error(p[2]), .rx_overrun(p[3]), .rx_abort(p[4]),
        .rx_open_byte(p[5]), .rx_fifo_count, .tx_fifo_count,
        .tx_msg_sent(p[0]));
    initial forever #25 hclk = ~hclk;
    always @(posedge hclk) begin
        if (++cyc == 3000) bad_count++;
        if (cyc == 3000) report_and_stop();
    end
    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask : ck
    // single word transfer; a read compares against d
    task automatic x(input logic w, input logic [7:0] a, input logic [31:0] d);
        {hsel, htrans, hwrite} <= {1'b1, 2'h2, w};
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        {hsel, htrans} <= 3'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        ck({31'h0, hresp}, 32'h0);
        if (!w) ck(hrdata, d);
    endtask : x
    task automatic ci(input logic e);
        @(posedge hclk);
        @(negedge hclk);
        ck({31'h0, irq}, {31'h0, e});
        @(posedge hclk);
    endtask : ci
    task automatic ev(input int k);
        if (k < 6) p <= 6'h01 << k;
        else code_valid <= !code_valid;
        @(posedge hclk);
        p <= 6'h00;
    endtask : ev
    task automatic t_regs;
        x(1'b1, 8'h08, 32'ha5);
        x(1'b0, 8'h08, 32'ha5);
        x(1'b0, 8'h0c, 32'h00);
    endtask : t_regs
    task automatic t_events;
        logic [7:0] ex[8] = '{8'h01, 8'h40, 8'h40, 8'h40, 8'h40, 8'h20,
            8'h80, 8'h80};
        // software follows a code change with a status read
        // software follows packet bits with a status read
        for (int k = 0; k < 8; k++) begin
            ev(k);
            x(1'b0, 8'h04, {24'h0, ex[k]});
            x(1'b0, 8'h04, 32'h00);
        end
    endtask : t_events
    task automatic t_levels;
        logic [17:0] tv[5] = '{18'h02f0a, 18'h1080a, 18'h1271e, 18'h2001e,
            18'h01000};
        for (int k = 0; k < 5; k++) begin
            {rx_fifo_count, tx_fifo_count} <= tv[k][17:8];
            repeat (2) @(posedge hclk);
            x(1'b0, 8'h04, {24'h0, tv[k][7:0]});
        end
    endtask : t_levels
    task automatic t_irq;
        x(1'b1, 8'h08, 32'h01);
        ev(0);
        ci(1'b1);
        x(1'b1, 8'h08, 32'h00);
        ci(1'b0);
        x(1'b1, 8'h08, 32'h01);
        ci(1'b1);
        x(1'b0, 8'h04, 32'h01);
        ci(1'b0);
    endtask : t_irq
    task automatic report_and_stop;
        if (bad_count == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    initial begin
        {hresetn, hsel, hwrite, code_valid, p, htrans} = 12'h0;
        {haddr, hwdata, rx_fifo_count, tx_fifo_count} = 74'h10;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_events();
        t_levels();
        t_irq();
        report_and_stop();
    end
endmodule : tb_top
